// ==== hw/fbmc_pkg.sv ====
// Shared constants, types and the query check table for the flash bank mode controller.
package fbmc_pkg;

  localparam int ADDR_W = 23;
  localparam int DATA_W = 32;

  // Register byte offsets on the APB side.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;

  // Field positions inside the command, status, config and address registers.
  localparam int CMD_OP_LSB = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_MISMATCH_BIT = 2;
  localparam int ST_MODE_LSB = 8;
  localparam int CFG_WORD_BIT = 0;
  localparam int CFG_BUSY_LSB = 4;
  localparam int BANK_MSB = ADDR_W - 1;
  localparam int BANK_LSB = ADDR_W - 2;

  // Flash command cycle values.
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 23'h000555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 23'h0002aa;
  localparam logic [ADDR_W-1:0] ADDR_QUERY = 23'h000055;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 23'h000000;

  // Bus timing, in ns and in 50 ns clock cycles (least times rounded up).
  localparam int CLK_NS = 50;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 3;
  localparam int CNT_W = 4;

  typedef enum logic [1:0] {MODE_READ, MODE_SUSP, MODE_AUTO, MODE_AUTO_SUSP} fbmc_mode_t;
  typedef enum logic [2:0] {OP_WRITE, OP_READ, OP_RESET, OP_AUTOSEL, OP_QUERY, OP_SUSPEND,
                            OP_RESUME} fbmc_op_t;

  // Pins that the controller drives toward the flash.
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic word_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
  } fbmc_pins_t;

  // One bus cycle of a command sequence.
  typedef struct packed {
    logic rd;
    logic last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbmc_cycle_t;

  // Expected query contents: check flag, compare mask and value per double-word offset.
  typedef struct packed {
    logic check;
    logic [7:0] mask;
    logic [7:0] value;
  } fbmc_expect_t;

  function automatic fbmc_expect_t fbmc_query_expect(input logic [7:0] off);
    fbmc_expect_t e;
    e = '{check: 1'b1, mask: 8'hff, value: 8'h00};
    unique case (off)
      8'h40: e.value = 8'h50;
      8'h41: e.value = 8'h52;
      8'h42: e.value = 8'h49;
      8'h45: begin
        e.mask = 8'h03;
        e.value = 8'h00;
      end
      8'h46: e.value = 8'h02;
      8'h4a: e.value = 8'he7;
      8'h4b: e.value = 8'h00;
      8'h4c: e.value = 8'h02;
      8'h4f: e.value = 8'h01;
      8'h50: e.value = 8'h00;
      8'h57: e.value = 8'h04;
      8'h58: e.value = 8'h27;
      8'h59: e.value = 8'h60;
      8'h5a: e.value = 8'h60;
      8'h5b: e.value = 8'h27;
      default: e.check = 1'b0;
    endcase
    return e;
  endfunction : fbmc_query_expect

endpackage : fbmc_pkg

// ==== hw/fbmc_sync.sv ====
// Three-stage synchroniser for the flash data pins with a stability flag.
`timescale 1ns/1ps
`default_nettype none
module fbmc_sync #(
  parameter int W = 32
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q,
  output logic o_stable
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_s1;
  logic [W-1:0] next_s2;
  logic [W-1:0] next_s3;

  // The first stage feeds only the second; stability compares the later two.
  always_comb begin
    next_s1 = i_d;
    next_s2 = s1;
    next_s3 = s2;
  end

  // Stage registers.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  assign o_q = s3;
  assign o_stable = (s2 == s3);

endmodule : fbmc_sync
`default_nettype wire

// ==== hw/fbmc_host.sv ====
// Host-side controller that drives a multi-bank parallel flash from APB commands.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fbmc_host
  import fbmc_pkg::*;
#(
  parameter int BANKS = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic [fbmc_pkg::DATA_W-1:0] i_dq,
  output fbmc_pkg::fbmc_pins_t o_pins
);
  import fbmc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_SAMPLE, ST_HOLD} fbmc_state_t;

  fbmc_state_t state, next_state;
  fbmc_op_t op, next_op;
  fbmc_mode_t mode [BANKS];
  fbmc_mode_t next_mode [BANKS];
  fbmc_pins_t pins, next_pins;
  logic [1:0] step, next_step;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [ADDR_W-1:0] addr_reg, next_addr_reg;
  logic [DATA_W-1:0] wdata, next_wdata;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic word_mode, next_word_mode;
  logic [BANKS-1:0] bank_busy, next_bank_busy;
  logic refused, next_refused;
  logic mismatch, next_mismatch;
  logic pready, next_pready;
  logic [31:0] prdata, next_prdata;
  logic pslverr, next_pslverr;
  logic [DATA_W-1:0] dq_sync;
  logic dq_stable;
  fbmc_cycle_t cyc;
  fbmc_expect_t expect_q;
  logic apb_access;
  logic cmd_start;
  logic [BANK_MSB-BANK_LSB:0] sel_bank;

  fbmc_sync #(.W(DATA_W)) u_dq_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_d(i_dq),
    .o_q(dq_sync),
    .o_stable(dq_stable)
  );

  // Builds each bus cycle of the selected sequence; sequences are issued whole.
  function automatic fbmc_cycle_t seq_cycle(input fbmc_op_t o, input logic [1:0] s,
                                            input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                                            input logic wm);
    fbmc_cycle_t c;
    logic [ADDR_W-1:0] bank_base;
    logic [ADDR_W-1:0] qaddr;
    bank_base = {a[BANK_MSB:BANK_LSB], {BANK_LSB{1'b0}}};
    qaddr = wm ? {{(ADDR_W-9){1'b0}}, a[7:0], 1'b0} : {{(ADDR_W-8){1'b0}}, a[7:0]};
    c = '{rd: 1'b0, last: 1'b1, addr: a, data: d};
    unique case (o)
      OP_WRITE: c.rd = 1'b0;
      OP_READ: c.rd = 1'b1;
      OP_RESET: c = '{rd: 1'b0, last: 1'b1, addr: ADDR_ZERO, data: {24'h000000, CMD_RESET}};
      OP_AUTOSEL: begin
        // Two unlock writes then the command at the bank address.
        c.last = (s == 2'h2);
        c.addr = (s == 2'h0) ? ADDR_UNLOCK1 : (s == 2'h1) ? ADDR_UNLOCK2 : (bank_base | ADDR_UNLOCK1);
        c.data = {24'h000000, (s == 2'h0) ? CMD_UNLOCK1 : (s == 2'h1) ? CMD_UNLOCK2 : CMD_AUTOSEL};
      end
      OP_QUERY: begin
        // Enter query, read one location, then reset back to array reads.
        c.last = (s == 2'h2);
        c.rd = (s == 2'h1);
        c.addr = (s == 2'h0) ? ADDR_QUERY : (s == 2'h1) ? qaddr : ADDR_ZERO;
        c.data = {24'h000000, (s == 2'h0) ? CMD_QUERY : CMD_RESET};
      end
      OP_SUSPEND: c = '{rd: 1'b0, last: 1'b1, addr: bank_base, data: {24'h000000, CMD_SUSPEND}};
      OP_RESUME: c = '{rd: 1'b0, last: 1'b1, addr: bank_base, data: {24'h000000, CMD_RESUME}};
      default: c.last = 1'b1;
    endcase
    return c;
  endfunction : seq_cycle

  assign apb_access = i_psel && i_penable && !pready;
  assign cmd_start = apb_access && i_pwrite && (i_paddr == REG_CMD) && (state == ST_IDLE);
  assign sel_bank = addr_reg[BANK_MSB:BANK_LSB];
  assign cyc = seq_cycle(op, step, addr_reg, wdata, word_mode);
  assign expect_q = fbmc_query_expect(addr_reg[7:0]);

  // Sequencer: drives one bus cycle at a time and updates the per-bank mode mirror.
  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_cnt = cnt;
    next_pins = pins;
    next_rdata = rdata;
    next_refused = refused;
    next_mismatch = mismatch;
    next_mode = mode;
    next_pins.word_n = !word_mode;
    unique case (state)
      ST_IDLE: begin
        next_pins.ce_n = 1'b1;
        next_pins.we_n = 1'b1;
        next_pins.oe_n = 1'b1;
        next_pins.dq_oe = 1'b0;
        if (cmd_start) begin
          next_op = fbmc_op_t'(i_pwdata[CMD_OP_LSB +: 3]);
          next_step = 2'h0;
          next_refused = 1'b0;
          next_state = ST_SETUP;
          if (fbmc_op_t'(i_pwdata[CMD_OP_LSB +: 3]) == OP_AUTOSEL &&
              ((mode[sel_bank] != MODE_READ && mode[sel_bank] != MODE_SUSP) || (|bank_busy))) begin
            next_refused = 1'b1;
            next_state = ST_IDLE;
          end
          if (fbmc_op_t'(i_pwdata[CMD_OP_LSB +: 3]) == OP_QUERY && (|bank_busy)) begin
            next_refused = 1'b1;
            next_state = ST_IDLE;
          end
        end
      end
      ST_SETUP: begin
        // Address and chip select first, so the later falling edge sees a stable address.
        next_pins.addr = cyc.addr;
        next_pins.ce_n = 1'b0;
        next_pins.oe_n = !cyc.rd;
        next_pins.dq = cyc.data;
        next_pins.dq_oe = !cyc.rd;
        next_cnt = cyc.rd ? CNT_W'(ACC_CYC + SYNC_CYC) : CNT_W'(WP_CYC);
        next_state = ST_STROBE;
      end
      ST_STROBE: begin
        next_pins.we_n = cyc.rd;
        if (cnt > CNT_W'(1)) begin
          next_cnt = cnt - CNT_W'(1);
        end else begin
          next_state = cyc.rd ? ST_SAMPLE : ST_HOLD;
        end
      end
      ST_SAMPLE: begin
        if (dq_stable) begin
          next_rdata = word_mode && op == OP_QUERY ? {24'h000000, dq_sync[7:0]} : dq_sync;
          if (op == OP_QUERY && expect_q.check) begin
            next_mismatch = ((dq_sync[7:0] & expect_q.mask) != expect_q.value);
          end
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Strobes rise while address and data stay driven, so the first rising edge latches valid data.
        next_pins.we_n = 1'b1;
        next_pins.ce_n = 1'b1;
        next_pins.oe_n = 1'b1;
        if (cyc.last) begin
          next_state = ST_IDLE;
          unique case (op)
            OP_RESET, OP_QUERY: begin // Both end with a reset command written to the flash.
              for (int b = 0; b < BANKS; b++) begin
                if (mode[b] == MODE_AUTO) next_mode[b] = MODE_READ;
                if (mode[b] == MODE_AUTO_SUSP) next_mode[b] = MODE_SUSP;
              end
            end
            OP_AUTOSEL: next_mode[sel_bank] = (mode[sel_bank] == MODE_SUSP) ? MODE_AUTO_SUSP : MODE_AUTO;
            OP_SUSPEND: next_mode[sel_bank] = MODE_SUSP;
            OP_RESUME: next_mode[sel_bank] = MODE_READ;
            default: next_mode = mode;
          endcase
        end else begin
          next_step = step + 2'h1;
          next_state = ST_SETUP;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer registers; every bank mirrors array-read after reset.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
      op <= OP_WRITE;
      step <= 2'h0;
      cnt <= '0;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, word_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
      rdata <= '0;
      refused <= 1'b0;
      mismatch <= 1'b0;
      for (int b = 0; b < BANKS; b++) mode[b] <= MODE_READ;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      cnt <= next_cnt;
      pins <= next_pins;
      rdata <= next_rdata;
      refused <= next_refused;
      mismatch <= next_mismatch;
      mode <= next_mode;
    end
  end

  // APB slave: one wait state, registered answer, error on unmapped or busy command writes.
  always_comb begin
    next_pready = apb_access;
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    next_addr_reg = addr_reg;
    next_wdata = wdata;
    next_word_mode = word_mode;
    next_bank_busy = bank_busy;
    if (apb_access) begin
      unique case (i_paddr)
        REG_CMD: next_pslverr = i_pwrite && (state != ST_IDLE);
        REG_ADDR: begin
          if (i_pwrite && state == ST_IDLE) next_addr_reg = i_pwdata[ADDR_W-1:0];
          next_prdata = {{(32-ADDR_W){1'b0}}, addr_reg};
        end
        REG_WDATA: begin
          if (i_pwrite && state == ST_IDLE) next_wdata = i_pwdata;
          next_prdata = wdata;
        end
        REG_RDATA: next_prdata = rdata;
        REG_STATUS: begin
          next_prdata[ST_BUSY_BIT] = (state != ST_IDLE);
          next_prdata[ST_REFUSED_BIT] = refused;
          next_prdata[ST_MISMATCH_BIT] = mismatch;
          for (int b = 0; b < BANKS; b++) next_prdata[ST_MODE_LSB + 2*b +: 2] = mode[b];
        end
        REG_CONFIG: begin
          if (i_pwrite) begin
            next_word_mode = i_pwdata[CFG_WORD_BIT];
            next_bank_busy = i_pwdata[CFG_BUSY_LSB +: BANKS];
          end
          next_prdata[CFG_WORD_BIT] = word_mode;
          next_prdata[CFG_BUSY_LSB +: BANKS] = bank_busy;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // APB and configuration registers.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      addr_reg <= '0;
      wdata <= '0;
      word_mode <= 1'b0;
      bank_busy <= '0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      addr_reg <= next_addr_reg;
      wdata <= next_wdata;
      word_mode <= next_word_mode;
      bank_busy <= next_bank_busy;
    end
  end

  assign o_pready = pready;
  assign o_prdata = prdata;
  assign o_pslverr = pslverr;
  assign o_pins = pins;

endmodule : fbmc_host
`default_nettype wire

// ==== tb/fbmc_host_asserts.sv ====
// Checker for the controller's flash pins and APB answers.
`timescale 1ns/1ps
`default_nettype none
module fbmc_host_asserts (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic [fbmc_pkg::DATA_W-1:0] i_dq,
  input wire fbmc_pkg::fbmc_pins_t o_pins
);
  import fbmc_pkg::*;
  logic [15:0] hist;
  logic [15:0] next_hist;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Keeps the last two command bytes seen under a write strobe.
  always_comb next_hist = !o_pins.we_n ? {hist[7:0], o_pins.dq[7:0]} : hist;
  always_ff @(posedge i_clk) hist <= next_hist;
  // One write cycle: setup, a single strobe cycle, then release.
  sequence s_strobe;
    o_pins.we_n ##1 !o_pins.we_n ##1 o_pins.we_n;
  endsequence
  sequence s_addr_held;
    $stable(o_pins.addr) ##1 $stable(o_pins.addr);
  endsequence
  AST_WRITE_CYCLE: assert property ($fell(o_pins.ce_n) && o_pins.dq_oe |-> s_strobe)
    else $error("write cycle shape wrong");
  AST_ADDR_STABLE: assert property ($fell(o_pins.we_n) |-> s_addr_held)
    else $error("address moved during strobe");
  AST_DATA_HELD: assert property ($rose(o_pins.we_n) |-> o_pins.dq_oe && $stable(o_pins.dq))
    else $error("data not held at strobe rise");
  AST_WE_QUAL: assert property (!o_pins.we_n |-> !o_pins.ce_n && o_pins.oe_n && o_pins.dq_oe)
    else $error("write strobe without select or data");
  AST_NO_FIGHT: assert property (!o_pins.oe_n |-> !o_pins.dq_oe)
    else $error("output enable while driving data");
  AST_CE_BOUND: assert property ($fell(o_pins.ce_n) |-> ##[1:40] o_pins.ce_n)
    else $error("select held too long");
  AST_AUTOSEL_ORDER: assert property ($fell(o_pins.we_n) && o_pins.dq[7:0] == CMD_AUTOSEL |->
    hist == {CMD_UNLOCK1, CMD_UNLOCK2})
    else $error("autoselect without unlock pair");
  AST_PREADY_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb answer late");
  AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("apb ready held");
  AST_RESET_IDLE: assert property (disable iff (1'b0) !i_reset_n |=> o_pins.ce_n && o_pins.we_n &&
    o_pins.oe_n && !o_pins.dq_oe && !o_pready)
    else $error("pins not idle in reset");
endmodule : fbmc_host_asserts
bind fbmc_host fbmc_host_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_dq(i_dq), .o_pins(o_pins));
`default_nettype wire

// ==== tb/fbmc_flash_model.sv ====
// Behavioural four-bank flash as seen from its pins.
`timescale 1ns/1ps
`default_nettype none
module fbmc_flash_model #(
  parameter int ACC_NS = 60
) (
  input wire fbmc_pkg::fbmc_pins_t i_pins,
  output logic [31:0] o_dq,
  output logic [22:0] o_last_addr,
  output logic [31:0] o_last_data,
  output logic [7:0] o_mode
);
  import fbmc_pkg::*;
  logic [1:0] md [4] = '{default: 2'd0};
  logic [1:0] step = 2'd0;
  logic qry = 1'b0;
  logic [31:0] held = 32'h0;
  logic [31:0] val;
  logic [7:0] off;
  logic wr, rd;
  logic [1:0] b;
  // Strobe decode; the query offset halves in sixteen-bit mode.
  assign wr = !i_pins.ce_n && !i_pins.we_n;
  assign rd = !i_pins.ce_n && !i_pins.oe_n && !i_pins.dq_oe;
  assign b = o_last_addr[BANK_MSB:BANK_LSB];
  assign off = i_pins.word_n ? i_pins.addr[7:0] : i_pins.addr[8:1];
  assign o_mode = {md[3], md[2], md[1], md[0]};
  // Array data or query table contents.
  always_comb begin
    val = {9'h0, i_pins.addr};
    if (qry) begin
      case (off)
        8'h40: val = 32'h50;
        8'h41: val = 32'h52;
        8'h42: val = 32'h49;
        8'h45: val = 32'h04;
        8'h46: val = 32'h02;
        8'h4a: val = 32'he7;
        8'h4c: val = 32'h02;
        8'h4f: val = 32'h01;
        8'h57: val = 32'h04;
        8'h58: val = 32'h27;
        8'h59: val = 32'h60;
        8'h5a: val = 32'h60;
        8'h5b: val = 32'h27;
        default: val = 32'h0;
      endcase
    end
  end
  // Address latched when the later strobe falls.
  always @(posedge wr) o_last_addr = i_pins.addr;
  // Data latched at the first strobe rise, then decoded.
  always @(negedge wr) begin
    o_last_data = i_pins.dq;
    if (i_pins.dq[7:0] == CMD_RESET) begin
      qry = 1'b0;
      step = 2'd0;
      foreach (md[i]) md[i] = {1'b0, md[i][0]};
    end else if (i_pins.dq[7:0] == CMD_QUERY) qry = 1'b1;
    else if (step == 2'd0 && i_pins.dq[7:0] == CMD_UNLOCK1) step = 2'd1;
    else if (step == 2'd1 && i_pins.dq[7:0] == CMD_UNLOCK2) step = 2'd2;
    else if (step == 2'd2 && i_pins.dq[7:0] == CMD_AUTOSEL && !md[b][1]) begin
      md[b] = md[b] | 2'd2;
      step = 2'd0;
    end else if (i_pins.dq[7:0] == CMD_SUSPEND) md[b] = 2'd1;
    else if (i_pins.dq[7:0] == CMD_RESUME) md[b] = 2'd0;
    else step = 2'd0;
  end
  // A released bus shows the inverse of the last value read.
  always @(negedge rd) held = val;
  assign #ACC_NS o_dq = rd ? val : ~held;
endmodule : fbmc_flash_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the flash bank mode controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fbmc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, mmode;
  logic [31:0] pwdata, prdata, dq, mdata, rdat;
  logic [22:0] maddr;
  fbmc_pins_t pins;
  int err_total = 0;
  int total_checks = 0;
  logic [7:0] qo [14] = '{8'h40, 8'h41, 8'h42, 8'h46, 8'h4a, 8'h4b, 8'h4c, 8'h4f, 8'h50, 8'h57, 8'h58,
    8'h59, 8'h5a, 8'h5b};
  logic [7:0] qv [14] = '{8'h50, 8'h52, 8'h49, 8'h02, 8'he7, 8'h00, 8'h02, 8'h01, 8'h00, 8'h04, 8'h27,
    8'h60, 8'h60, 8'h27};
  fbmc_host dut (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_dq(dq), .o_pins(pins));
  fbmc_flash_model flash (.i_pins(pins), .o_dq(dq), .o_last_addr(maddr), .o_last_data(mdata), .o_mode(mmode));
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      tally_and_finish();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic st(input logic [31:0] e, input logic [7:0] m);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", e, rdat);
    chk("flash mode", {24'h0, m}, {24'h0, mmode});
  endtask : st
  // Polls the status register until the sequencer is idle again.
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rdat[ST_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_total++;
      tally_and_finish();
    end
  endtask : idle
  task automatic op(input fbmc_op_t c, input logic [31:0] a);
    apb(1'b1, REG_ADDR, a);
    apb(1'b1, REG_CMD, {29'h0, c});
    idle();
  endtask : op
  task automatic t_basic;
    st(32'h0, 8'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'b1, REG_WDATA, 32'h89ab_cd77);
    op(OP_WRITE, 32'h0012_3456);
    chk("latched addr", 32'h0012_3456, {9'h0, maddr});
    chk("latched data", 32'h89ab_cd77, mdata);
    op(OP_READ, 32'h0055_0f0f);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("array read", 32'h0055_0f0f, rdat);
  endtask : t_basic
  task automatic t_query;
    for (int i = 0; i < 14; i++) begin
      op(OP_QUERY, {24'h0, qo[i]});
      apb(1'b0, REG_RDATA, 32'h0);
      chk("query data", {24'h0, qv[i]}, rdat);
      st(32'h0, 8'h0);
    end
    op(OP_QUERY, 32'h45);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("unlock field", 32'h0, {30'h0, rdat[1:0]});
    apb(1'b1, REG_CONFIG, 32'h1);
    op(OP_QUERY, 32'h41);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("word query", 32'h52, rdat);
    apb(1'b1, REG_CONFIG, 32'h0);
    st(32'h0, 8'h0);
  endtask : t_query
  task automatic t_modes;
    op(OP_AUTOSEL, 32'h0040_0000);
    st(32'h2000, 8'h20);
    op(OP_RESET, 32'h007f_ffff);
    st(32'h0, 8'h0);
    op(OP_SUSPEND, 32'h0020_0000);
    st(32'h400, 8'h04);
    op(OP_AUTOSEL, 32'h0020_0000);
    st(32'hc00, 8'h0c);
    op(OP_RESET, 32'h0);
    st(32'h400, 8'h04);
    op(OP_RESUME, 32'h0020_0000);
    st(32'h0, 8'h0);
    op(OP_AUTOSEL, 32'h0060_0000);
    st(32'h8000, 8'h80);
    op(OP_QUERY, 32'h40);
    st(32'h0, 8'h0);
  endtask : t_modes
  task automatic t_busy;
    apb(1'b1, REG_CONFIG, 32'h10);
    op(OP_AUTOSEL, 32'h0060_0000);
    st(32'h2, 8'h0);
    apb(1'b1, REG_CONFIG, 32'h0);
    op(OP_RESET, 32'h0);
    st(32'h0, 8'h0);
    apb(1'b1, REG_CMD, {29'h0, OP_READ});
    apb(1'b1, REG_CMD, {29'h0, OP_RESET});
    chk("busy command error", 32'h1, {31'h0, rerr});
    idle();
    apb(1'b1, REG_CONFIG, 32'h80);
    op(OP_QUERY, 32'h40);
    st(32'h2, 8'h0);
    apb(1'b1, REG_CONFIG, 32'h0);
    op(OP_RESET, 32'h0);
    st(32'h0, 8'h0);
  endtask : t_busy
  // Reset, then the scenarios in turn.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_basic();
    t_query();
    t_modes();
    t_busy();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
